// ==== gpio_edge_irq.sv ====
// Operation
// R01: falling-edge mask, set 1Ch, clear 1Dh
// R02: rising-edge mask, set 1Eh, clear 1Fh
// R03: mask bit zero blocks that pin edge
// R04: fields readable, settable, clearable bit by bit
// R05: set and clear address read same contents
// R06: ones written to set address set bits
// R07: ones written to clear address clear bits
// R08: bits written zero keep their value
// R09: latch at 1Ah/1Bh records interrupting pins
// R10: pins map bits 0-2; bits 3-7 never interrupt (code: bits 3-7 set through 1Ah still raise irq_o)
// R11: edges found comparing current and previous sample
`timescale 1ns/1ns
`default_nettype none
`include "gpio_irq_cfg.svh"

module gpio_edge_irq (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire gpio_irq_pkg::pin_vec_t pins_i,
  input wire gpio_irq_pkg::reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic irq_o
);

  gpio_irq_pkg::irq_state_t state_reg;
  gpio_irq_pkg::irq_state_t state_next;

  logic [7:0] latch_q;
  logic [7:0] fall_q;
  logic [7:0] rise_q;
  logic [7:0] fall_set;
  logic [7:0] fall_clr;
  logic [7:0] rise_set;
  logic [7:0] rise_clr;
  logic [7:0] latch_set;
  logic [7:0] latch_clr;
  logic [7:0] latch_hw;
  gpio_irq_pkg::pin_vec_t rise_evt;
  gpio_irq_pkg::pin_vec_t fall_evt;
  logic wr_fall_set;
  logic wr_fall_clr;
  logic wr_rise_set;
  logic wr_rise_clr;
  logic wr_latch_set;
  logic wr_latch_clr;

  // address decode: each write only sets or clears ones
  assign wr_fall_set = reg_req_i.wr && (reg_req_i.addr == `GIRQ_FALL_SET); // R01 R04
  assign wr_fall_clr = reg_req_i.wr && (reg_req_i.addr == `GIRQ_FALL_CLR); // R01 R04
  assign wr_rise_set = reg_req_i.wr && (reg_req_i.addr == `GIRQ_RISE_SET); // R02 R04
  assign wr_rise_clr = reg_req_i.wr && (reg_req_i.addr == `GIRQ_RISE_CLR); // R02 R04
  assign wr_latch_set = reg_req_i.wr && (reg_req_i.addr == `GIRQ_LATCH_SET); // R09 R04
  assign wr_latch_clr = reg_req_i.wr && (reg_req_i.addr == `GIRQ_LATCH_CLR); // R09 R04

  // write data turned into set and clear vectors
  assign fall_set = wr_fall_set ? reg_req_i.wdata : 8'h00; // R06
  assign fall_clr = wr_fall_clr ? reg_req_i.wdata : 8'h00; // R07
  assign rise_set = wr_rise_set ? reg_req_i.wdata : 8'h00; // R06
  assign rise_clr = wr_rise_clr ? reg_req_i.wdata : 8'h00; // R07
  assign latch_set = wr_latch_set ? reg_req_i.wdata : 8'h00; // R06
  assign latch_clr = wr_latch_clr ? reg_req_i.wdata : 8'h00; // R07

  // edge detection per pin, gated by the enable masks
  genvar gi;
  generate
    for (gi = `GIRQ_PIN_LSB; gi <= `GIRQ_PIN_MSB; gi++) begin : g_pin
      assign rise_evt[gi] = state_reg.primed && pins_i[gi] && !state_reg.prev_pins[gi] && rise_q[gi]; // R02 R03 R11
      assign fall_evt[gi] = state_reg.primed && !pins_i[gi] && state_reg.prev_pins[gi] && fall_q[gi]; // R01 R03 R11
    end
  endgenerate

  // only pin bits can be set by hardware
  assign latch_hw = {5'h00, rise_evt | fall_evt}; // R10

  setclr_reg #(
    .RESET_VALUE(`GIRQ_FALL_RST)
  ) u_fall_mask (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(fall_set),
    .clr_i(fall_clr),
    .hw_set_i(8'h00),
    .value_o(fall_q)
  );

  setclr_reg #(
    .RESET_VALUE(`GIRQ_RISE_RST)
  ) u_rise_mask (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(rise_set),
    .clr_i(rise_clr),
    .hw_set_i(8'h00),
    .value_o(rise_q)
  );

  setclr_reg #(
    .RESET_VALUE(`GIRQ_LATCH_RST)
  ) u_latch (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(latch_set),
    .clr_i(latch_clr),
    .hw_set_i(latch_hw),
    .value_o(latch_q)
  );

  // next state: pin history, read port and interrupt line
  always_comb begin
    state_next = state_reg;
    state_next.prev_pins = pins_i; // R11
    state_next.primed = 1'b1;
    state_next.irq = |latch_q; // R09
    state_next.rvalid = reg_req_i.rd;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `GIRQ_LATCH_SET, `GIRQ_LATCH_CLR: begin
          state_next.rdata = latch_q; // R05
        end
        `GIRQ_FALL_SET, `GIRQ_FALL_CLR: begin
          state_next.rdata = fall_q; // R05
        end
        `GIRQ_RISE_SET, `GIRQ_RISE_CLR: begin
          state_next.rdata = rise_q; // R05
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg.prev_pins <= `GIRQ_PINS_RST;
      state_reg.primed <= 1'b0;
      state_reg.irq <= 1'b0;
      state_reg.rvalid <= 1'b0;
      state_reg.rdata <= `GIRQ_RDATA_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o = state_reg.rdata;
  assign reg_rvalid_o = state_reg.rvalid;
  assign irq_o = state_reg.irq;

  // helper signals for the checks below
  logic [7:0] wdata_w;
  logic rd_w;
  logic [7:0] addr_w;
  assign wdata_w = reg_req_i.wdata;
  assign rd_w = reg_req_i.rd;
  assign addr_w = reg_req_i.addr;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence fall_set_wr_s;
    wr_fall_set;
  endsequence

  sequence rise_clr_wr_s;
    wr_rise_clr;
  endsequence

  sequence pin0_rise_s;
    state_reg.primed && pins_i[0] && !state_reg.prev_pins[0];
  endsequence

  sequence pin0_fall_s;
    state_reg.primed && !pins_i[0] && state_reg.prev_pins[0];
  endsequence

  fall_set_bits_a: assert property (fall_set_wr_s |=> ((fall_q & $past(wdata_w)) == $past(wdata_w))) // R06
    else $error("set address did not set written ones");
  fall_keep_bits_a: assert property (fall_set_wr_s |=> ((fall_q & ~$past(wdata_w)) == ($past(fall_q) & ~$past(wdata_w)))) // R08
    else $error("set address changed bits written as zero");
  rise_clr_bits_a: assert property (rise_clr_wr_s |=> ((rise_q & $past(wdata_w)) == 8'h00)) // R07
    else $error("clear address did not clear written ones");
  rise_keep_bits_a: assert property (rise_clr_wr_s |=> ((rise_q & ~$past(wdata_w)) == ($past(rise_q) & ~$past(wdata_w)))) // R08
    else $error("clear address changed bits written as zero");
  read_alias_a: assert property ((rd_w && (addr_w == `GIRQ_FALL_CLR)) |=> (reg_rvalid_o && (reg_rdata_o == $past(fall_q)))) // R05
    else $error("clear address read differs from register");
  rise_latch_a: assert property ((pin0_rise_s and (rise_q[0] == 1'b1)) |=> latch_q[0]) // R02
    else $error("enabled rising edge not latched");
  fall_latch_a: assert property ((pin0_fall_s and (fall_q[0] == 1'b1)) |=> latch_q[0]) // R01
    else $error("enabled falling edge not latched");
  masked_edge_a: assert property ((!latch_q[0] && !wr_latch_set
    && !(state_reg.primed && pins_i[0] && !state_reg.prev_pins[0] && rise_q[0])
    && !(state_reg.primed && !pins_i[0] && state_reg.prev_pins[0] && fall_q[0])) |=> !latch_q[0]) // R03
    else $error("latch bit set without enabled edge");
  spare_bits_a: assert property (!wr_latch_set |=> ((latch_q[7:3] & ~$past(latch_q[7:3])) == 5'h00)) // R10
    else $error("spare latch bit set by hardware");
  irq_follow_a: assert property ((latch_q != 8'h00) |=> irq_o ##1 (irq_o || ($past(latch_q) == 8'h00))) // R09
    else $error("interrupt line does not follow latch");

endmodule // gpio_edge_irq

`default_nettype wire

// ==== gpio_irq_cfg.svh ====
`ifndef GPIO_IRQ_CFG_SVH
`define GPIO_IRQ_CFG_SVH

// register offsets on the serial control interface
`define GIRQ_LATCH_SET 8'h1a
`define GIRQ_LATCH_CLR 8'h1b
`define GIRQ_FALL_SET 8'h1c
`define GIRQ_FALL_CLR 8'h1d
`define GIRQ_RISE_SET 8'h1e
`define GIRQ_RISE_CLR 8'h1f

// field layout: pins sit in bits 0 to 2
`define GIRQ_PIN_LSB 0
`define GIRQ_PIN_MSB 2
`define GIRQ_SPARE_LSB 3
`define GIRQ_SPARE_MSB 7

// reset values
`define GIRQ_LATCH_RST 8'h00
`define GIRQ_FALL_RST 8'h00
`define GIRQ_RISE_RST 8'h00
`define GIRQ_RDATA_RST 8'h00
`define GIRQ_PINS_RST 3'h0

`endif

// ==== gpio_irq_pkg.sv ====
`default_nettype none

package gpio_irq_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] pin_vec_t;

  // one register access from the serial control interface
  typedef struct packed {
    logic wr;
    logic rd;
    reg_byte_t addr;
    reg_byte_t wdata;
  } reg_req_t;

  // state of one set/clear register
  typedef struct packed {
    reg_byte_t value;
  } setclr_state_t;

  // state of the top block
  typedef struct packed {
    pin_vec_t prev_pins;
    logic primed;
    logic irq;
    logic rvalid;
    reg_byte_t rdata;
  } irq_state_t;

endpackage

`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output var gpio_irq_pkg::reg_req_t reg_req_o
);
  // idle bus after power up
  initial begin
    reg_req_o = 18'h00000;
  end

  // one access held over a single taking edge, then the lines are scrambled
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_req_o = {w, ~w, a, d};
    @(posedge clk_sys_i);
    #1;
    reg_req_o = {1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask

  // answer is registered on the taking edge and read 1 ns after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    put(1'b0, a, 8'h00);
    v = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
endmodule // host_model

`default_nettype wire

// ==== setclr_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gpio_irq_cfg.svh"

module setclr_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire gpio_irq_pkg::reg_byte_t set_i,
  input wire gpio_irq_pkg::reg_byte_t clr_i,
  input wire gpio_irq_pkg::reg_byte_t hw_set_i,
  output logic [7:0] value_o
);

  gpio_irq_pkg::setclr_state_t state_reg;
  gpio_irq_pkg::setclr_state_t state_next;

  // ones clear, then ones set; hardware set wins over a clear
  always_comb begin
    state_next = state_reg;
    state_next.value = (state_reg.value & ~clr_i) | set_i | hw_set_i; // R06 R07 R08
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg.value <= RESET_VALUE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value_o = state_reg.value;

endmodule // setclr_reg

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
  logic clk_sys_i;
  logic rst_n_i;
  gpio_irq_pkg::pin_vec_t pins;
  gpio_irq_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic irq;
  logic [7:0] d;
  logic v;
  int fails = 0;
  int total_checks = 0;
  // write address, write data, read address, expected read data
  logic [7:0] rows [8][4] = '{
    '{8'h1c, 8'h28, 8'h1d, 8'h28}, '{8'h1c, 8'h88, 8'h1c, 8'ha8},
    '{8'h1d, 8'h88, 8'h1c, 8'h20}, '{8'h1d, 8'h20, 8'h1d, 8'h00},
    '{8'h1e, 8'hff, 8'h1f, 8'hff}, '{8'h1f, 8'hf8, 8'h1e, 8'h07},
    '{8'h10, 8'hff, 8'h10, 8'h00}, '{8'h1c, 8'h00, 8'h1e, 8'h07}};

  gpio_edge_irq i_dut (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pins_i(pins),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid),
    .irq_o(irq)
  );

  host_model i_host (
    .clk_sys_i(clk_sys_i),
    .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid),
    .reg_req_o(req)
  );

  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // read one register and compare valid strobe and data
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask

  // move the pins, then let the edge detector and irq flop settle
  task automatic set_pins(input logic [2:0] p);
    @(posedge clk_sys_i);
    #1;
    pins = p;
    repeat (3) @(posedge clk_sys_i);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // hang guard
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    rst_n_i = 1'b0;
    pins = 3'h0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    rd_chk(8'h1c, 8'h00);
    // set and clear through both addresses of each mask
    for (int i = 0; i < 8; i++) begin
      i_host.wr(rows[i][0], rows[i][1]);
      rd_chk(rows[i][2], rows[i][3]);
    end
    // rise enable 07, fall enable 00 until the writes to 1Fh and 1Ch below
    set_pins(3'h2);
    rd_chk(8'h1a, 8'h02);
    `CHK(irq, 1'b1)
    i_host.wr(8'h1b, 8'h02);
    rd_chk(8'h1b, 8'h00);
    `CHK(irq, 1'b0)
    i_host.wr(8'h1f, 8'h01);
    i_host.wr(8'h1c, 8'h01);
    set_pins(3'h3);
    rd_chk(8'h1a, 8'h00);
    set_pins(3'h2);
    rd_chk(8'h1a, 8'h01);
    set_pins(3'h0);
    rd_chk(8'h1a, 8'h01);
    i_host.wr(8'h1b, 8'h01);
    i_host.wr(8'h1a, 8'h80);
    rd_chk(8'h1b, 8'h80);
    `CHK(irq, 1'b1)
    // second reset with pins high: no rising edge may be seen
    @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b0;
    pins = 3'h7;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    `CHK(irq, 1'b0)
    rd_chk(8'h1e, 8'h00);
    rd_chk(8'h1c, 8'h00);
    i_host.wr(8'h1e, 8'h07);
    set_pins(3'h7);
    rd_chk(8'h1a, 8'h00);
    // pin 0 low then high again: enabled rising edge after reset
    set_pins(3'h6);
    set_pins(3'h7);
    rd_chk(8'h1a, 8'h01);
    `CHK(irq, 1'b1)
    wrap_up();
  end
endmodule // tb

`default_nettype wire
